//--- include/spl_pkg.sv
// Package with offsets, field positions, resets and timing for the power/indicator bank
package spl_pkg;

    // Register offsets on the host register port
    localparam logic [7:0] ADDR_TAG_INSERT  = 8'hc2;
    localparam logic [7:0] ADDR_PWR_IND     = 8'hc3;
    localparam logic [7:0] ADDR_SLEEP_DELAY = 8'hc4;
    localparam logic [7:0] ADDR_FWD_HOST    = 8'hc6;

    // Field positions of the tag insert register
    localparam int BIT_INS_P3_P1 = 1;
    localparam int BIT_INS_P3_P2 = 0;

    // Field positions of the power and indicator register
    localparam int BIT_HOSTIF_GATE = 7;
    localparam int BIT_FABRIC_GATE = 6;
    localparam int IND_MODE_HI     = 5;
    localparam int IND_MODE_LO     = 4;
    localparam int BIT_IND_DEBUG   = 3;
    localparam int BIT_PLL_OFF     = 2;
    localparam int PM_MODE_HI      = 1;
    localparam int PM_MODE_LO      = 0;

    // Field positions of the forward/host register
    localparam int FWD_MASK_HI  = 6;
    localparam int FWD_MASK_LO  = 4;
    localparam int HOST_MODE_HI = 1;
    localparam int HOST_MODE_LO = 0;

    // Reset values
    localparam logic [7:0] RST_TAG_INSERT  = 8'h00;
    localparam logic [7:0] RST_PWR_IND     = 8'h00;
    localparam logic [7:0] RST_SLEEP_DELAY = 8'h50;
    localparam logic [2:0] RST_FWD_MASK    = 3'h0;
    localparam logic [1:0] RST_HOST_MODE   = 2'h0;

    // Indicator function encodings
    localparam logic [1:0] IND_LNKACT_SPEED  = 2'h0;
    localparam logic [1:0] IND_LINK_ACT      = 2'h1;
    localparam logic [1:0] IND_LNKACT_DUPLEX = 2'h2;
    localparam logic [1:0] IND_LINK_DUPLEX   = 2'h3;

    // Power management modes
    localparam logic [1:0] PM_NORMAL       = 2'h0;
    localparam logic [1:0] PM_ENERGY_DET   = 2'h1;
    localparam logic [1:0] PM_SW_POWERDOWN = 2'h2;
    localparam logic [1:0] PM_POWER_SAVE   = 2'h3;

    // Host interface modes
    localparam logic [1:0] HOST_I2C_MASTER = 2'h0;
    localparam logic [1:0] HOST_I2C_SLAVE  = 2'h1;
    localparam logic [1:0] HOST_SPI_SLAVE  = 2'h2;
    localparam logic [1:0] HOST_SERIAL_MGT = 2'h3;

    // Timing: sleep delay unit
    localparam int CLK_HZ         = 25_000_000;
    localparam int SLEEP_UNIT_MS  = 20;
    localparam int SLEEP_UNIT_CYC = (CLK_HZ / 1000) * SLEEP_UNIT_MS;

    // Strap capture wait, cycles after reset release
    localparam logic [1:0] STRAP_WAIT = 2'h3;

endpackage

//--- rtl/spl_sleep_timer.sv
// Energy-detect sleep entry timer with 20 ms unit divider
module spl_sleep_timer #(
    parameter int UNIT_CYC = spl_pkg::SLEEP_UNIT_CYC
) (
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       arst_n,
    // Control
    input  wire logic       enable,
    input  wire logic       energy,
    input  wire logic [7:0] delay_units,
    // Status
    output logic            sleep
);
    localparam int CW = $clog2(UNIT_CYC + 1);

    logic [CW-1:0] div_reg;
    logic [7:0]    units_reg;
    logic          sleep_reg;
    wire           quiet    = enable & ~energy;
    wire           unit_end = (div_reg == CW'(UNIT_CYC - 1));
    wire           units_sat = (units_reg == 8'hff);

    // Divider runs only through quiet time; energy restarts the whole wait
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            div_reg <= '0;
        end else if (!quiet || unit_end) begin
            div_reg <= '0;
        end else begin
            div_reg <= div_reg + CW'(1);
        end
    end

    // Whole units of continuous quiet, saturating
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            units_reg <= 8'h00;
        end else if (!quiet) begin
            units_reg <= 8'h00;
        end else if (unit_end && !units_sat) begin
            units_reg <= units_reg + 8'h01;
        end
    end

    // Low power only after the full programmed quiet span
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            sleep_reg <= 1'b0;
        end else begin
            sleep_reg <= quiet && (units_reg >= delay_units);
        end
    end

    assign sleep = sleep_reg;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    AST_SLEEP_NEEDS_QUIET: assert property (
        sleep |-> $past(enable) && !$past(energy))
        else $error("sleep asserted without quiet energy-detect mode");

    AST_SLEEP_NOT_EARLY: assert property (
        $rose(sleep) |-> $past(units_reg) >= $past(delay_units))
        else $error("sleep entered before delay elapsed");

    AST_ENERGY_WAKES: assert property (
        energy && delay_units != 8'h00 |=> !sleep [*2])
        else $error("sleep held despite energy");
endmodule

//--- rtl/spl_top.sv
// Power, indicator and host-mode configuration bank of the switch
module spl_top #(
    parameter int SLEEP_UNIT_CYC = spl_pkg::SLEEP_UNIT_CYC
) (
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       arst_n,
    // Host register port
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_wr_en,
    input  wire logic [7:0] reg_wr_data,
    input  wire logic       reg_rd_en,
    output logic      [7:0] reg_rd_data,
    // Strap pins
    input  wire logic       port2_indicator_strap_hi,
    input  wire logic       port2_indicator_strap_lo,
    // Port status from the switch core
    input  wire logic       port_link,
    input  wire logic       port_activity,
    input  wire logic       port_speed,
    input  wire logic       port_duplex,
    input  wire logic       device_ready,
    // Stretched energy signal from the analog side
    input  wire logic       energy_detect,
    // Indicator pins
    output logic            indicator_out_a,
    output logic            indicator_out_b,
    // Datapath and power controls
    output logic            insert_p3_to_p1,
    output logic            insert_p3_to_p2,
    output logic            hostif_clk_gate_en,
    output logic            fabric_clk_gate_en,
    output logic            pll_off_en,
    output logic      [1:0] power_mode,
    output logic            low_power_state,
    output logic      [2:0] invalid_vid_fwd_mask,
    output logic      [1:0] host_if_mode,
    output logic            host_if_mode_valid
);
    logic [1:0] ins_reg;
    logic [7:0] pwr_reg;
    logic [7:0] delay_reg;
    logic [2:0] fwd_reg;
    logic [1:0] host_reg;
    logic [7:0] rd_reg;
    logic       ind_a_reg;
    logic       ind_b_reg;
    logic [2:0] energy_sync;
    logic       energy_hold_reg;
    logic [2:0] strap_hi_sync;
    logic [2:0] strap_lo_sync;
    logic [1:0] strap_cnt;
    logic       strap_done;

    // Address decode
    wire wr_ins   = reg_wr_en && (reg_addr == spl_pkg::ADDR_TAG_INSERT);
    wire wr_pwr   = reg_wr_en && (reg_addr == spl_pkg::ADDR_PWR_IND);
    wire wr_delay = reg_wr_en && (reg_addr == spl_pkg::ADDR_SLEEP_DELAY);
    wire wr_fwd   = reg_wr_en && (reg_addr == spl_pkg::ADDR_FWD_HOST);

    // Synchronised pin levels, taken once second and third stage agree
    wire energy_agree = (energy_sync[2] == energy_sync[1]);
    wire energy_s     = energy_agree ? energy_sync[2] : energy_hold_reg;
    wire strap_hi_s = strap_hi_sync[1];
    wire strap_lo_s = strap_lo_sync[1];
    wire straps_agree = (strap_hi_sync[2] == strap_hi_sync[1]) &&
                        (strap_lo_sync[2] == strap_lo_sync[1]);

    // Write-only-by-host fields; reserved bits are never stored
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ins_reg   <= spl_pkg::RST_TAG_INSERT[1:0];
            pwr_reg   <= spl_pkg::RST_PWR_IND;
            delay_reg <= spl_pkg::RST_SLEEP_DELAY;
            fwd_reg   <= spl_pkg::RST_FWD_MASK;
        end else begin
            if (wr_ins) begin
                ins_reg <= reg_wr_data[1:0];
            end
            if (wr_pwr) begin
                pwr_reg <= reg_wr_data;
            end
            if (wr_delay) begin
                delay_reg <= reg_wr_data;
            end
            if (wr_fwd) begin
                fwd_reg <= reg_wr_data[spl_pkg::FWD_MASK_HI:spl_pkg::FWD_MASK_LO];
            end
        end
    end

    // Pin synchronisers
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            energy_sync     <= 3'h0;
            energy_hold_reg <= 1'b0;
            strap_hi_sync <= 3'h0;
            strap_lo_sync <= 3'h0;
        end else begin
            energy_sync     <= {energy_sync[1:0], energy_detect};
            energy_hold_reg <= energy_s; // Level kept while stages disagree
            strap_hi_sync <= {strap_hi_sync[1:0], port2_indicator_strap_hi};
            strap_lo_sync <= {strap_lo_sync[1:0], port2_indicator_strap_lo};
        end
    end

    // Strap capture after release; a reset constant cannot hold a pin level
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            strap_cnt  <= 2'h0;
            strap_done <= 1'b0;
            host_reg   <= spl_pkg::RST_HOST_MODE;
        end else if (!strap_done) begin
            if (strap_cnt != spl_pkg::STRAP_WAIT) begin
                strap_cnt <= strap_cnt + 2'h1;
            end else if (straps_agree) begin
                host_reg   <= {strap_hi_s, strap_lo_s};
                strap_done <= 1'b1;
            end
        end else if (wr_fwd) begin
            host_reg <= reg_wr_data[spl_pkg::HOST_MODE_HI:spl_pkg::HOST_MODE_LO];
        end
    end

    // Read mux; reserved bits and unmapped offsets read zero
    wire [7:0] rd_mux =
        (reg_addr == spl_pkg::ADDR_TAG_INSERT)  ? {6'h00, ins_reg} :
        (reg_addr == spl_pkg::ADDR_PWR_IND)     ? pwr_reg :
        (reg_addr == spl_pkg::ADDR_SLEEP_DELAY) ? delay_reg :
        (reg_addr == spl_pkg::ADDR_FWD_HOST)    ? {1'b0, fwd_reg, 2'h0, host_reg} :
                                                  8'h00;

    // Read data held until the next read
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rd_reg <= 8'h00;
        end else if (reg_rd_en) begin
            rd_reg <= rd_mux;
        end
    end

    // Indicator function selection
    wire [1:0] ind_mode  = pwr_reg[spl_pkg::IND_MODE_HI:spl_pkg::IND_MODE_LO];
    wire       ind_debug = pwr_reg[spl_pkg::BIT_IND_DEBUG];
    wire       link_act  = port_link & ~port_activity; // Blinks off on traffic
    wire       norm_a    = ind_mode[0] ? port_link : link_act;
    wire       norm_b    =
        (ind_mode == spl_pkg::IND_LNKACT_SPEED) ? port_speed :
        (ind_mode == spl_pkg::IND_LINK_ACT)     ? port_activity :
                                                  port_duplex;

    // Indicator pins registered so debug switching cannot glitch
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ind_a_reg <= 1'b0;
            ind_b_reg <= 1'b0;
        end else begin
            ind_a_reg <= ind_debug ? ~device_ready : norm_a;
            ind_b_reg <= ind_debug ? ~energy_s : norm_b;
        end
    end

    // Sleep entry only counts in energy-detect mode
    wire ed_mode = (power_mode == spl_pkg::PM_ENERGY_DET);

    spl_sleep_timer #(
        .UNIT_CYC    (SLEEP_UNIT_CYC)
    ) u_sleep (
        .clk_sys     (clk_sys),
        .arst_n      (arst_n),
        .enable      (ed_mode),
        .energy      (energy_s),
        .delay_units (delay_reg),
        .sleep       (low_power_state)
    );

    // Control outputs straight from the stored fields
    assign insert_p3_to_p1      = ins_reg[spl_pkg::BIT_INS_P3_P1];
    assign insert_p3_to_p2      = ins_reg[spl_pkg::BIT_INS_P3_P2];
    assign hostif_clk_gate_en   = pwr_reg[spl_pkg::BIT_HOSTIF_GATE];
    assign fabric_clk_gate_en   = pwr_reg[spl_pkg::BIT_FABRIC_GATE];
    assign pll_off_en           = pwr_reg[spl_pkg::BIT_PLL_OFF];
    assign power_mode           = pwr_reg[spl_pkg::PM_MODE_HI:spl_pkg::PM_MODE_LO];
    assign invalid_vid_fwd_mask = fwd_reg;
    assign host_if_mode         = host_reg;
    assign host_if_mode_valid   = strap_done;
    assign indicator_out_a      = ind_a_reg;
    assign indicator_out_b      = ind_b_reg;
    assign reg_rd_data          = rd_reg;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    sequence s_wr_ins;
        wr_ins;
    endsequence
    sequence s_wr_pwr;
        wr_pwr;
    endsequence

    AST_INSERT_P1: assert property (
        s_wr_ins |=> insert_p3_to_p1 == $past(reg_wr_data[1]))
        else $error("port 3 to port 1 insert not taken");
    AST_INSERT_P2: assert property (
        s_wr_ins |=> insert_p3_to_p2 == $past(reg_wr_data[0]))
        else $error("port 3 to port 2 insert not taken");
    AST_HOSTIF_GATE: assert property (
        s_wr_pwr |=> hostif_clk_gate_en == $past(reg_wr_data[7]))
        else $error("host clock gating not taken");
    AST_FABRIC_GATE: assert property (
        s_wr_pwr |=> fabric_clk_gate_en == $past(reg_wr_data[6]))
        else $error("fabric clock gating not taken");
    AST_IND_LINK_ACT: assert property (
        !ind_debug && ind_mode == spl_pkg::IND_LINK_ACT |=>
        indicator_out_a == $past(port_link) && indicator_out_b == $past(port_activity))
        else $error("indicator link/activity mode wrong");
    AST_IND_DEBUG: assert property (
        ind_debug |=> indicator_out_a == !$past(device_ready) &&
        indicator_out_b == !$past(energy_s))
        else $error("indicator debug mode wrong");
    AST_PLL_PM: assert property (
        s_wr_pwr |=> pll_off_en == $past(reg_wr_data[2]) &&
        power_mode == $past(reg_wr_data[1:0]))
        else $error("pll or power mode not taken");
    AST_FWD_MASK: assert property (
        wr_fwd |=> invalid_vid_fwd_mask == $past(reg_wr_data[6:4]))
        else $error("invalid vid mask not taken");
    AST_STRAP_LOAD: assert property (
        $rose(strap_done) |-> host_if_mode == {$past(strap_hi_s), $past(strap_lo_s)})
        else $error("host mode not loaded from straps");
    AST_READBACK: assert property (
        reg_rd_en && reg_addr == spl_pkg::ADDR_SLEEP_DELAY && !wr_delay |=>
        reg_rd_data == $past(delay_reg))
        else $error("sleep delay readback wrong");
endmodule

//--- bench/spl_top_test.sv
// Self-checking bench for the power, indicator and host-mode bank
module spl_top_test;
    timeunit 1ns;
    timeprecision 1ps;

    logic       clk_sys, arst_n, reg_wr_en, reg_rd_en;
    logic [7:0] reg_addr, reg_wr_data, reg_rd_data, rd_val;
    logic       strap_hi, strap_lo, link, act, speed, duplex, ready, energy;
    logic       ind_a, ind_b, ins_p1, ins_p2, hgate, fgate, pll_off, low_pwr, hm_valid;
    logic [1:0] pwr_mode, host_mode;
    logic [2:0] fwd_mask;
    logic [7:0] m_c2, m_c3, m_c4, m_c6, addr_tab [6], d;
    integer     fail_count, comparisons, seed, i, n;

    // Sleep unit cut to 10 cycles so a quiet span fits the run
    spl_top #(.SLEEP_UNIT_CYC(10)) i_spl_top (
        .clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
        .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data),
        .port2_indicator_strap_hi(strap_hi), .port2_indicator_strap_lo(strap_lo),
        .port_link(link), .port_activity(act), .port_speed(speed), .port_duplex(duplex),
        .device_ready(ready), .energy_detect(energy), .indicator_out_a(ind_a),
        .indicator_out_b(ind_b), .insert_p3_to_p1(ins_p1), .insert_p3_to_p2(ins_p2),
        .hostif_clk_gate_en(hgate), .fabric_clk_gate_en(fgate), .pll_off_en(pll_off),
        .power_mode(pwr_mode), .low_power_state(low_pwr), .invalid_vid_fwd_mask(fwd_mask),
        .host_if_mode(host_mode), .host_if_mode_valid(hm_valid)
    );

    // Free-running system clock, 40 ns
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        comparisons = comparisons + 1;
        if (seen !== exp) begin
            fail_count = fail_count + 1;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up;
        $display("fail_count=%0d comparisons=%0d", fail_count, comparisons);
        if (fail_count == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Write strobe lasts one cycle; model keeps only the bits that exist
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        reg_addr    <= a;
        reg_wr_data <= v;
        reg_wr_en   <= 1'b1;
        @(posedge clk_sys);
        reg_wr_en   <= 1'b0;
        case (a)
            8'hc2:   m_c2 = v & 8'h03;
            8'hc3:   m_c3 = v;
            8'hc4:   m_c4 = v;
            8'hc6:   m_c6 = v & 8'h73;
            default: ;
        endcase
    endtask

    // Read data is picked up once the registered answer has settled
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_rd_en <= 1'b1;
        @(posedge clk_sys);
        reg_rd_en <= 1'b0;
        @(posedge clk_sys);
        #1;
        v = reg_rd_data;
    endtask

    function automatic logic [7:0] exp_rd(input logic [7:0] a);
        case (a)
            8'hc2:   return m_c2;
            8'hc3:   return m_c3;
            8'hc4:   return m_c4;
            8'hc6:   return m_c6;
            default: return 8'h00;
        endcase
    endfunction

    task automatic chk_ctrl;
        @(posedge clk_sys);
        #1;
        chk({ins_p1, ins_p2}, {14'h0, m_c2[1:0]});
        chk({hgate, fgate, pll_off}, {13'h0, m_c3[7:6], m_c3[2]});
        chk({14'h0, pwr_mode}, {14'h0, m_c3[1:0]});
        chk({fwd_mask, host_mode}, {11'h0, m_c6[6:4], m_c6[1:0]});
    endtask

    // Watchdog sized well above the expected run length
    initial begin
        #2000000;
        fail_count = fail_count + 1;
        wrap_up();
    end

    initial begin
        fail_count = 0;
        comparisons = 0;
        seed = 14035;
        addr_tab = '{8'hc2, 8'hc3, 8'hc4, 8'hc6, 8'hc5, 8'hc0};
        {arst_n, reg_wr_en, reg_rd_en, reg_addr, reg_wr_data} = '0;
        {link, act, speed, duplex, ready} = '0;
        strap_hi = 1'b1;
        strap_lo = 1'b0;
        energy = 1'b1;
        m_c2 = 8'h00;
        m_c3 = 8'h00;
        m_c4 = 8'h50;
        m_c6 = {6'h0, 2'b10};
        repeat (12) @(posedge clk_sys);
        arst_n <= 1'b1;
        repeat (8) @(posedge clk_sys);
        #1;
        chk({15'h0, hm_valid}, 16'h1);
        // Reset values and unmapped places
        foreach (addr_tab[k]) begin
            rd(addr_tab[k], rd_val);
            chk(rd_val, exp_rd(addr_tab[k]));
        end
        chk_ctrl();
        // Random writes with read-back, reserved bits masked
        for (i = 0; i < 32; i = i + 1) begin
            n = $unsigned($random(seed)) % 6;
            d = $random(seed);
            // Host keeps c6 reserved bits at defaults and c2 bits 7:6 clear, gating only in normal mode
            case (addr_tab[n])
                8'hc2:   d = d & 8'h3f;
                8'hc3:   d = (d[1:0] == 2'h0) ? d : (d & 8'h3f);
                8'hc6:   d = d & 8'h73;
                8'hc0:   d = 8'h03;
                default: ;
            endcase
            wr(addr_tab[n], d);
            chk_ctrl();
            rd(addr_tab[n], rd_val);
            chk(rd_val, exp_rd(addr_tab[n]));
        end
        // Both gating bits and PLL off, traffic stopped in normal mode
        wr(8'hc3, 8'hc4);
        chk_ctrl();
        // Every indicator mode, then debug output
        for (i = 0; i < 8; i = i + 1) begin
            wr(8'hc3, {2'b00, i[1:0], i[2], 3'b000});
            for (n = 0; n < 4; n = n + 1) begin
                d = $random(seed);
                @(posedge clk_sys);
                {link, act, speed, duplex, ready} <= d[4:0];
                repeat (2) @(posedge clk_sys);
                #1;
                if (i[2]) begin
                    chk({ind_a, ind_b}, {14'h0, ~d[0], ~energy});
                end else begin
                    chk({ind_a, ind_b}, {14'h0, i[0] ? d[4] : d[4] & ~d[3],
                        i[1] ? d[1] : (i[0] ? d[3] : d[2])});
                end
            end
        end
        // Energy-detect sleep entry after three quiet units
        wr(8'hc4, 8'h03);
        wr(8'hc3, 8'h01);
        repeat (10) @(posedge clk_sys);
        energy <= 1'b0;
        n = 0;
        while (low_pwr !== 1'b1 && n < 200) begin
            @(posedge clk_sys);
            #1;
            n = n + 1;
        end
        chk({15'h0, (n >= 30 && n <= 36)}, 16'h1);
        @(posedge clk_sys);
        energy <= 1'b1;
        repeat (6) @(posedge clk_sys);
        #1;
        chk({15'h0, low_pwr}, 16'h0);
        // Quiet in normal mode never sleeps
        wr(8'hc3, 8'h00);
        energy <= 1'b0;
        repeat (60) @(posedge clk_sys);
        #1;
        chk({15'h0, low_pwr}, 16'h0);
        // Second reset with other strap levels: defaults and strap load again
        @(posedge clk_sys);
        strap_hi <= 1'b0;
        strap_lo <= 1'b1;
        arst_n   <= 1'b0;
        repeat (3) @(posedge clk_sys);
        arst_n <= 1'b1;
        m_c2 = 8'h00;
        m_c3 = 8'h00;
        m_c4 = 8'h50;
        m_c6 = 8'h01;
        #1;
        chk({15'h0, hm_valid}, 16'h0);
        repeat (8) @(posedge clk_sys);
        #1;
        chk({15'h0, hm_valid}, 16'h1);
        foreach (addr_tab[k]) begin
            rd(addr_tab[k], rd_val);
            chk(rd_val, exp_rd(addr_tab[k]));
        end
        chk_ctrl();
        chk({15'h0, low_pwr}, 16'h0);
        wrap_up();
    end
endmodule
